// File: rtl/card_register_contents.sv
// Purpose: Card-side register contents read by the host over the card bus
// Assumes: Command decoding sits outside; it hands over program, width and address strobes
// Notes: All register images are flop outputs refreshed every cycle
// What this block does
// - Device size field is reported so that capacity is (size + 1) times 512 kilobytes.
// - Format group, copy, permanent lock and file format change once only via the program command.
// - Temporary lock and the reserved pair 9:8 are rewritten by every program command that is not refused.
// - Bits 7:1 of the card-specific data hold its checksum and bit 0 reads as one.
// - Write block length code 1001 sits in bits 25:22 and partial writes bit 21 is clear.
// - The power-up-complete bit stays low until the internal power-up routine ends.
// - Capacity status is bit 30 and busy/ready bit 31 of the conditions word, zero meaning busy.
// - Erased-data-state bit 55 is clear and erased locations read as all-ones bytes.
// - Command-support bits 35:32 read 11, set-block-count and speed-class control supported.
// - A 16-bit relative address is held and may be reassigned after initialization.
// - Bus width is reported in status bits 511:510, 2 meaning four bits, tracking changes.
`timescale 1ns/1ps
`default_nettype none
module card_register_contents
  import card_regs_pkg::*;
#(
  parameter int POWERUP_CYC = POWERUP_CYCLES,
  parameter int DEVICE_SIZE = 15000,
  parameter logic CAPACITY_HIGH = 1'b1,
  parameter logic [31:0] PROTECTED_SIZE = 32'h00000000
) (
  input wire logic sys_clk_i,               // Card clock, 25 MHz
  input wire logic rst_i,                   // Synchronous reset, active high
  input wire logic prog_valid_i,            // Program-card-data command strobe
  input wire logic [PROG_W-1:0] prog_data_i, // New card-specific data bits 15:0
  input wire logic width_valid_i,           // Bus width change strobe
  input wire logic [1:0] width_i,           // Requested bus width code
  input wire logic rca_assign_i,            // Relative address assignment strobe
  input wire logic [RCA_W-1:0] rca_new_i,   // New relative address
  output logic [CSD_W-1:0] csd_o,           // Card-specific data image
  output logic [SCR_W-1:0] scr_o,           // Special-features image
  output logic [RCA_W-1:0] rca_o,           // Relative address
  output logic [SSR_W-1:0] ssr_o,           // Status record image
  output logic [OCR_W-1:0] ocr_o,           // Operating-conditions word
  output logic [7:0] erased_fill_o,         // Byte returned for erased locations
  output logic prog_ack_o,                  // Program command taken, one cycle
  output logic prog_refused_o,              // Program command refused, one cycle
  output logic powered_o                    // Power-up routine finished
);

  generate
    if (DEVICE_SIZE < 0 || DEVICE_SIZE >= (1 << CSD_CSIZE_W)) begin : g_bad_size
      $error("DEVICE_SIZE does not fit the device size field");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Power-up routine

  logic pwr_done;

  powerup_timer #(
    .CYCLES(POWERUP_CYC)
  ) u_powerup (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .done_o(pwr_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Programmable card-specific data bits

  // One-time bits packed as {format group, copy, permanent lock, format[1:0]}
  function automatic logic [4:0] otp_of(input logic [PROG_W-1:0] d);
    otp_of = {d[CSD_FMT_GRP_POS], d[CSD_COPY_POS], d[CSD_PERM_POS], d[CSD_FMT_LSB +: 2]};
  endfunction

  logic [4:0] otp_reg, otp_next;
  logic otp_used_reg, otp_used_next;
  logic tmp_lock_reg, tmp_lock_next;
  logic [1:0] rsv98_reg, rsv98_next;
  logic ack_next, refused_next;
  logic otp_differs;

  assign otp_differs = otp_of(prog_data_i) != otp_reg;

  always_comb begin
    otp_next = otp_reg;
    otp_used_next = otp_used_reg;
    tmp_lock_next = tmp_lock_reg;
    rsv98_next = rsv98_reg;
    ack_next = 1'b0;
    refused_next = 1'b0;
    if (rst_i) begin
      otp_next = '0;
      otp_used_next = 1'b0;
      tmp_lock_next = 1'b0;
      rsv98_next = '0;
    end else if (prog_valid_i) begin
      if (otp_used_reg && otp_differs) begin
        refused_next = 1'b1;
      end else begin
        ack_next = 1'b1;
        if (otp_differs) begin
          otp_next = otp_of(prog_data_i);
          otp_used_next = 1'b1;
        end
        tmp_lock_next = prog_data_i[CSD_TMP_POS];
        rsv98_next = prog_data_i[CSD_RSV98_LSB +: 2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Relative address and bus width

  logic [RCA_W-1:0] rca_next;
  logic [1:0] width_reg, width_next;

  always_comb begin
    rca_next = rca_o;
    width_next = width_reg;
    if (rst_i) begin
      rca_next = RCA_RESET;
      width_next = BUS_WIDTH_1BIT;
    end else begin
      if (rca_assign_i && pwr_done) begin
        rca_next = rca_new_i;
      end
      if (width_valid_i && (width_i == BUS_WIDTH_1BIT || width_i == BUS_WIDTH_4BIT)) begin
        width_next = width_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register images, assembled from next values so they follow changes in one cycle

  logic [CSD_W-1:0] csd_next;
  logic [SCR_W-1:0] scr_next;
  logic [SSR_W-1:0] ssr_next;
  logic [OCR_W-1:0] ocr_next;
  logic [CRC_W-1:0] csd_crc;
  logic [CSD_W-1:0] csd_body;

  always_comb begin
    csd_body = '0;
    csd_body[CSD_STRUCT_LSB +: 2] = CSD_STRUCT_VAL;
    csd_body[CSD_TAAC_LSB +: 8] = CSD_TAAC_VAL;
    csd_body[CSD_NSAC_LSB +: 8] = CSD_NSAC_VAL;
    csd_body[CSD_SPEED_LSB +: 8] = CSD_SPEED_VAL;
    csd_body[CSD_CCC_LSB +: 12] = CSD_CCC_VAL;
    csd_body[CSD_RBL_LSB +: 4] = CSD_RBL_VAL;
    csd_body[CSD_CSIZE_LSB +: CSD_CSIZE_W] = CSD_CSIZE_W'(DEVICE_SIZE);
    csd_body[CSD_ERASE_EN_POS] = 1'b1;
    csd_body[CSD_SECTOR_LSB +: 7] = CSD_SECTOR_VAL;
    csd_body[CSD_R2W_LSB +: 3] = CSD_R2W_VAL;
    csd_body[CSD_WBL_LSB +: 4] = CSD_WBL_VAL;
    csd_body[CSD_PARTIAL_POS] = 1'b0;
    csd_body[CSD_FMT_GRP_POS] = otp_next[4];
    csd_body[CSD_COPY_POS] = otp_next[3];
    csd_body[CSD_PERM_POS] = otp_next[2];
    csd_body[CSD_TMP_POS] = tmp_lock_next;
    csd_body[CSD_FMT_LSB +: 2] = otp_next[1:0];
    csd_body[CSD_RSV98_LSB +: 2] = rsv98_next;
  end

  crc7_calc #(
    .DATA_W(CRC_DATA_W)
  ) u_crc_next (
    .data_i(csd_body[CSD_W-1:CSD_BODY_LSB]),
    .crc_o(csd_crc)
  );

  always_comb begin
    csd_next = csd_body;
    csd_next[CSD_CRC_LSB +: CRC_W] = csd_crc;
    csd_next[CSD_ONE_POS] = 1'b1;

    scr_next = '0;
    scr_next[SCR_SPEC_LSB +: 4] = SCR_SPEC_VAL;
    scr_next[SCR_ERASED_POS] = 1'b0;
    scr_next[SCR_WIDTHS_LSB +: 4] = SCR_WIDTHS_VAL;
    scr_next[SCR_SPEC3_POS] = 1'b1;
    scr_next[SCR_SPEC4_POS] = 1'b1;
    scr_next[SCR_SPECX_LSB +: 4] = SCR_SPECX_VAL;
    scr_next[SCR_CMDSUP_LSB +: 4] = SCR_CMDSUP_VAL;

    ssr_next = '0;
    ssr_next[SSR_WIDTH_LSB +: 2] = width_next;
    ssr_next[SSR_PROT_LSB +: 32] = PROTECTED_SIZE;
    ssr_next[SSR_CLASS_LSB +: 8] = SSR_CLASS_VAL;
    ssr_next[SSR_AU_LSB +: 4] = SSR_AU_VAL;
    ssr_next[SSR_EU_LSB +: 16] = SSR_EU_VAL;
    ssr_next[SSR_ETO_LSB +: 6] = SSR_ETO_VAL;
    ssr_next[SSR_EOFS_LSB +: 2] = SSR_EOFS_VAL;
    ssr_next[SSR_UHSG_LSB +: 4] = SSR_UHSG_VAL;
    ssr_next[SSR_UHSAU_LSB +: 4] = SSR_UHSAU_VAL;

    // Capacity status is only driven once ready, so a busy word never shows it
    ocr_next = '0;
    ocr_next[OCR_VOLT_LSB +: 10] = OCR_VOLT_VAL;
    ocr_next[OCR_READY_POS] = pwr_done && !rst_i;
    ocr_next[OCR_CCS_POS] = CAPACITY_HIGH && pwr_done && !rst_i;
  end

  always_ff @(posedge sys_clk_i) begin
    otp_reg <= otp_next;
    otp_used_reg <= otp_used_next;
    tmp_lock_reg <= tmp_lock_next;
    rsv98_reg <= rsv98_next;
    width_reg <= width_next;
    rca_o <= rca_next;
    csd_o <= csd_next;
    scr_o <= scr_next;
    ssr_o <= ssr_next;
    ocr_o <= ocr_next;
    erased_fill_o <= ERASED_BYTE;
    prog_ack_o <= ack_next;
    prog_refused_o <= refused_next;
    powered_o <= pwr_done && !rst_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [CRC_W-1:0] csd_o_crc;

  crc7_calc #(
    .DATA_W(CRC_DATA_W)
  ) u_crc_check (
    .data_i(csd_o[CSD_W-1:CSD_BODY_LSB]),
    .crc_o(csd_o_crc)
  );

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_otp_change_attempt;
    prog_valid_i && otp_used_reg && otp_differs;
  endsequence

  sequence s_prog_taken;
    prog_valid_i && !(otp_used_reg && otp_differs);
  endsequence

  sequence s_width_legal;
    width_valid_i && (width_i == BUS_WIDTH_1BIT || width_i == BUS_WIDTH_4BIT);
  endsequence

  a_capacity_field: assert property (
    csd_o[CSD_CSIZE_LSB +: CSD_CSIZE_W] == CSD_CSIZE_W'(DEVICE_SIZE))
    else $error("device size field wrong");

  a_otp_refused: assert property (
    s_otp_change_attempt |=> prog_refused_o && !prog_ack_o && $stable(otp_reg)
      && $stable(csd_o[CSD_FMT_GRP_POS -: 8]))
    else $error("second one-time change was not refused");

  a_prog_quiet: assert property (
    !prog_valid_i |=> !prog_ack_o && !prog_refused_o)
    else $error("program answer without a command");

  a_tmp_rewrite: assert property (
    s_prog_taken |=> prog_ack_o && csd_o[CSD_TMP_POS] == $past(prog_data_i[CSD_TMP_POS])
      && csd_o[CSD_RSV98_LSB +: 2] == $past(prog_data_i[CSD_RSV98_LSB +: 2]))
    else $error("rewritable bits did not follow the program command");

  a_csd_checksum: assert property (
    csd_o[CSD_CRC_LSB +: CRC_W] == csd_o_crc && csd_o[CSD_ONE_POS])
    else $error("card data checksum or end bit wrong");

  a_write_block: assert property (
    csd_o[CSD_WBL_LSB +: 4] == CSD_WBL_VAL && !csd_o[CSD_PARTIAL_POS])
    else $error("write block fields wrong");

  a_ready_held: assert property (
    !pwr_done |=> !ocr_o[OCR_READY_POS] && !powered_o)
    else $error("ready shown before power-up finished");

  a_ccs_gated: assert property (
    ocr_o[OCR_CCS_POS] |-> ocr_o[OCR_READY_POS] && $past(pwr_done))
    else $error("capacity status shown while busy");

  a_erased_state: assert property (
    !scr_o[SCR_ERASED_POS] && erased_fill_o == ERASED_BYTE)
    else $error("erased data state wrong");

  a_cmd_support: assert property (
    scr_o[SCR_CMDSUP_LSB +: 4] == SCR_CMDSUP_VAL)
    else $error("command support field wrong");

  a_rca_assign: assert property (
    $changed(rca_o) && !$past(rst_i) |-> $past(rca_assign_i && pwr_done)
      && rca_o == $past(rca_new_i))
    else $error("relative address changed without a valid assignment");

  a_width_track: assert property (
    s_width_legal |=> ssr_o[SSR_WIDTH_LSB +: 2] == $past(width_i))
    else $error("status record width did not track");

  a_width_hold: assert property (
    !width_valid_i && !rst_i |=> $stable(ssr_o[SSR_WIDTH_LSB +: 2]))
    else $error("status record width changed without a request");

  a_reserved_zero: assert property (
    csd_o[20:16] == 5'h00 && ocr_o[29:25] == 5'h00 && scr_o[31:0] == 32'h00000000)
    else $error("reserved field not zero");

endmodule
`default_nettype wire

// File: rtl/crc7_calc.sv
// Purpose: Seven-bit checksum (x^7 + x^3 + 1) over a data vector, MSB first
// Assumes: Purely combinational
// Notes: Used for the card-specific data checksum
`timescale 1ns/1ps
`default_nettype none
module crc7_calc
  import card_regs_pkg::*;
#(
  parameter int DATA_W = CRC_DATA_W
) (
  input wire logic [DATA_W-1:0] data_i, // Data, first bit at MSB
  output logic [CRC_W-1:0] crc_o         // Resulting checksum
);

  generate
    if (DATA_W < 1) begin : g_bad_width
      $error("crc7_calc needs a data width of at least one");
    end
  endgenerate

  always_comb begin
    logic fb;
    crc_o = '0;
    fb = 1'b0;
    for (int i = DATA_W - 1; i >= 0; i--) begin
      fb = data_i[i] ^ crc_o[6];
      crc_o = {crc_o[5:0], 1'b0};
      crc_o[0] = fb;
      crc_o[3] = crc_o[3] ^ fb;
    end
  end

endmodule
`default_nettype wire

// File: rtl/powerup_timer.sv
// Purpose: Holds the card busy until its internal power-up routine has run
// Assumes: Synchronous active-high reset restarts the routine
// Notes: Done is a flop output and stays high until the next reset
`timescale 1ns/1ps
`default_nettype none
module powerup_timer
  import card_regs_pkg::*;
#(
  parameter int CYCLES = POWERUP_CYCLES
) (
  input wire logic sys_clk_i, // Card clock
  input wire logic rst_i,     // Synchronous reset, active high
  output logic done_o         // Power-up routine finished
);

  localparam int CNT_W = $clog2(CYCLES + 1);

  generate
    if (CYCLES < 1) begin : g_bad_cycles
      $error("powerup_timer needs at least one cycle");
    end
  endgenerate

  powerup_state_e state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic done_next;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    done_next = 1'b0;
    if (rst_i) begin
      state_next = PU_BUSY;
      cnt_next = '0;
    end else begin
      case (state_reg)
        PU_BUSY: begin
          if (cnt_reg == CNT_W'(CYCLES - 1)) begin
            state_next = PU_READY;
            done_next = 1'b1;
          end else begin
            cnt_next = cnt_reg + 1'b1;
          end
        end
        PU_READY: begin
          done_next = 1'b1;
        end
        default: begin
          state_next = PU_BUSY;
          cnt_next = '0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    state_reg <= state_next;
    cnt_reg <= cnt_next;
    done_o <= done_next;
  end

endmodule
`default_nettype wire

// File: shared/card_regs_pkg.sv
// Purpose: Shared constants for the card register contents block
// Assumes: Card clock of 25 MHz; field positions count from bit 0 of each register
// Notes: Values that vary with capacity are parameters of the top module
package card_regs_pkg;

  // Clock and power-up timing
  localparam int CLK_FREQ_MHZ = 25;
  localparam int POWERUP_TIME_US = 1000;
  localparam int POWERUP_CYCLES = POWERUP_TIME_US * CLK_FREQ_MHZ;

  // Register widths
  localparam int CSD_W = 128;
  localparam int SCR_W = 64;
  localparam int RCA_W = 16;
  localparam int SSR_W = 512;
  localparam int OCR_W = 32;
  localparam int PROG_W = 16;
  localparam int CRC_W = 7;
  localparam int CRC_DATA_W = 120;

  // Card-specific data fields
  localparam int CSD_STRUCT_LSB = 126;
  localparam logic [1:0] CSD_STRUCT_VAL = 2'h1;
  localparam int CSD_TAAC_LSB = 112;
  localparam logic [7:0] CSD_TAAC_VAL = 8'h0E;
  localparam int CSD_NSAC_LSB = 104;
  localparam logic [7:0] CSD_NSAC_VAL = 8'h00;
  localparam int CSD_SPEED_LSB = 96;
  localparam logic [7:0] CSD_SPEED_VAL = 8'h32;
  localparam int CSD_CCC_LSB = 84;
  localparam logic [11:0] CSD_CCC_VAL = 12'h5B5;
  localparam int CSD_RBL_LSB = 80;
  localparam logic [3:0] CSD_RBL_VAL = 4'h9;
  localparam int CSD_CSIZE_LSB = 48;
  localparam int CSD_CSIZE_W = 22;
  localparam int CSD_ERASE_EN_POS = 46;
  localparam int CSD_SECTOR_LSB = 39;
  localparam logic [6:0] CSD_SECTOR_VAL = 7'h7F;
  localparam int CSD_R2W_LSB = 26;
  localparam logic [2:0] CSD_R2W_VAL = 3'h2;
  localparam int CSD_WBL_LSB = 22;
  localparam logic [3:0] CSD_WBL_VAL = 4'h9;
  localparam int CSD_PARTIAL_POS = 21;
  localparam int CSD_FMT_GRP_POS = 15;
  localparam int CSD_COPY_POS = 14;
  localparam int CSD_PERM_POS = 13;
  localparam int CSD_TMP_POS = 12;
  localparam int CSD_FMT_LSB = 10;
  localparam int CSD_RSV98_LSB = 8;
  localparam int CSD_CRC_LSB = 1;
  localparam int CSD_ONE_POS = 0;
  localparam int CSD_BODY_LSB = 8;

  // Special-features fields
  localparam int SCR_SPEC_LSB = 56;
  localparam logic [3:0] SCR_SPEC_VAL = 4'h2;
  localparam int SCR_ERASED_POS = 55;
  localparam int SCR_WIDTHS_LSB = 48;
  localparam logic [3:0] SCR_WIDTHS_VAL = 4'h5;
  localparam int SCR_SPEC3_POS = 47;
  localparam int SCR_SPEC4_POS = 42;
  localparam int SCR_SPECX_LSB = 38;
  localparam logic [3:0] SCR_SPECX_VAL = 4'h2;
  localparam int SCR_CMDSUP_LSB = 32;
  localparam logic [3:0] SCR_CMDSUP_VAL = 4'h3;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // Status record fields
  localparam int SSR_WIDTH_LSB = 510;
  localparam logic [1:0] BUS_WIDTH_1BIT = 2'h0;
  localparam logic [1:0] BUS_WIDTH_4BIT = 2'h2;
  localparam int SSR_PROT_LSB = 448;
  localparam int SSR_CLASS_LSB = 440;
  localparam logic [7:0] SSR_CLASS_VAL = 8'h04;
  localparam int SSR_AU_LSB = 428;
  localparam logic [3:0] SSR_AU_VAL = 4'h9;
  localparam int SSR_EU_LSB = 408;
  localparam logic [15:0] SSR_EU_VAL = 16'h0008;
  localparam int SSR_ETO_LSB = 402;
  localparam logic [5:0] SSR_ETO_VAL = 6'h04;
  localparam int SSR_EOFS_LSB = 400;
  localparam logic [1:0] SSR_EOFS_VAL = 2'h1;
  localparam int SSR_UHSG_LSB = 396;
  localparam logic [3:0] SSR_UHSG_VAL = 4'h1;
  localparam int SSR_UHSAU_LSB = 392;
  localparam logic [3:0] SSR_UHSAU_VAL = 4'h9;

  // Operating-conditions word fields
  localparam int OCR_VOLT_LSB = 15;
  localparam logic [9:0] OCR_VOLT_VAL = 10'h3FF;
  localparam int OCR_CCS_POS = 30;
  localparam int OCR_READY_POS = 31;

  localparam logic [15:0] RCA_RESET = 16'h0000;

  typedef enum logic [1:0] {
    PU_BUSY = 2'b01,
    PU_READY = 2'b10
  } powerup_state_e;

endpackage

// File: verif/card_host_model.sv
// Purpose: Host-side model that issues program, width and address requests to the card
// Assumes: Requests launch just after a rising edge and are held for one edge
// Notes: Data lines flip to the inverse once a strobe drops, so stale values never look valid
`timescale 1ns/1ps
`default_nettype none
module card_host_model
  import card_regs_pkg::*;
(
  input wire logic sys_clk_i,              // Card clock
  input wire logic [OCR_W-1:0] ocr_i,      // Operating-conditions word
  output logic prog_valid_o,               // Program command strobe
  output logic [PROG_W-1:0] prog_data_o,   // Program data
  output logic width_valid_o,              // Width change strobe
  output logic [1:0] width_o,              // Width code
  output logic rca_assign_o,               // Address assignment strobe
  output logic [RCA_W-1:0] rca_new_o       // New address
);
  initial begin
    prog_valid_o = 1'b0;
    prog_data_o = 16'h0000;
    width_valid_o = 1'b0;
    width_o = 2'h1;
    rca_assign_o = 1'b0;
    rca_new_o = 16'hFFFF;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic prog(input logic [PROG_W-1:0] d, input logic hold);
    @(posedge sys_clk_i);
    prog_valid_o <= 1'b1;
    prog_data_o <= d;
    if (!hold) begin
      @(posedge sys_clk_i);
      prog_valid_o <= 1'b0;
      prog_data_o <= ~d;
    end
  endtask

  task automatic width(input logic [1:0] w);
    @(posedge sys_clk_i);
    width_valid_o <= 1'b1;
    width_o <= w;
    @(posedge sys_clk_i);
    width_valid_o <= 1'b0;
    width_o <= ~w;
  endtask

  task automatic relative_card_address(input logic [RCA_W-1:0] a);
    @(posedge sys_clk_i);
    rca_assign_o <= 1'b1;
    rca_new_o <= a;
    @(posedge sys_clk_i);
    rca_assign_o <= 1'b0;
    rca_new_o <= ~a;
  endtask

  // Capacity status is only believed once the ready bit is up
  task automatic read_capacity(output logic ready, output logic capacity_status_flag);
    ready = ocr_i[OCR_READY_POS];
    capacity_status_flag = (ready === 1'b1) ? ocr_i[OCR_CCS_POS] : 1'b0;
  endtask
endmodule
`default_nettype wire

// File: verif/test_card_register_contents.sv
// Purpose: Self-checking bench for the card register contents block
// Assumes: Short power-up count and a full-scale device size for the run
// Notes: Program commands and width changes run from tables, except one back-to-back program pair; power-up, address and reset are by hand
`timescale 1ns/1ps
`default_nettype none
module test_card_register_contents
  import card_regs_pkg::*;
();
  localparam int PU = 8;
  localparam int SIZE = 4194303;
  localparam logic [31:0] PROT = 32'h00123400;
  typedef struct packed {logic [15:0] d; logic ack; logic rf; logic [7:0] hi;} prog_row_s;
  typedef struct packed {logic [1:0] w; logic [1:0] e;} width_row_s;
  prog_row_s rows [6] = '{'{16'h105A, 1'b1, 1'b0, 8'h10}, '{16'h03C3, 1'b1, 1'b0, 8'h03},
    '{16'hA400, 1'b1, 1'b0, 8'hA4}, '{16'hB4FF, 1'b1, 1'b0, 8'hB4},
    '{16'h4401, 1'b0, 1'b1, 8'hB4}, '{16'hA700, 1'b1, 1'b0, 8'hA7}};
  width_row_s wrows [5] = '{'{2'h2, 2'h2}, '{2'h1, 2'h2}, '{2'h0, 2'h0}, '{2'h3, 2'h0},
    '{2'h2, 2'h2}};
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic prog_valid_i, width_valid_i, rca_assign_i, prog_ack_o, prog_refused_o, powered_o;
  logic [PROG_W-1:0] prog_data_i;
  logic [1:0] width_i;
  logic [RCA_W-1:0] rca_new_i, rca_o;
  logic [CSD_W-1:0] csd_o;
  logic [SCR_W-1:0] scr_o;
  logic [SSR_W-1:0] ssr_o;
  logic [OCR_W-1:0] ocr_o;
  logic [7:0] erased_fill_o;
  logic rdy, capacity_status_flag;
  int failures = 0;
  int checked = 0;

  always #20 sys_clk_i = ~sys_clk_i;

  card_register_contents #(.POWERUP_CYC(PU), .DEVICE_SIZE(SIZE), .CAPACITY_HIGH(1'b1),
    .PROTECTED_SIZE(PROT)) dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .prog_valid_i(prog_valid_i), .prog_data_i(prog_data_i), .width_valid_i(width_valid_i),
    .width_i(width_i), .rca_assign_i(rca_assign_i), .rca_new_i(rca_new_i), .csd_o(csd_o),
    .scr_o(scr_o), .rca_o(rca_o), .ssr_o(ssr_o), .ocr_o(ocr_o), .erased_fill_o(erased_fill_o),
    .prog_ack_o(prog_ack_o), .prog_refused_o(prog_refused_o), .powered_o(powered_o));

  card_host_model host (.sys_clk_i(sys_clk_i), .ocr_i(ocr_o), .prog_valid_o(prog_valid_i),
    .prog_data_o(prog_data_i), .width_valid_o(width_valid_i), .width_o(width_i),
    .rca_assign_o(rca_assign_i), .rca_new_o(rca_new_i));

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [6:0] crc7(input logic [119:0] d);
    logic [6:0] c;
    logic fb;
    c = 7'h00;
    for (int i = 119; i >= 0; i--) begin
      fb = d[i] ^ c[6];
      c = {c[5:0], 1'b0};
      if (fb) begin
        c = c ^ 7'h09;
      end
    end
    return c;
  endfunction

  function automatic logic [CSD_W-1:0] exp_csd(input logic [7:0] hi);
    logic [CSD_W-1:0] v;
    v = '0;
    v[127:80] = {2'h1, 6'h00, 8'h0E, 8'h00, 8'h32, 12'h5B5, 4'h9};
    v[69:48] = SIZE[21:0];
    v[46:39] = 8'hFF;
    v[28:26] = 3'h2;
    v[25:21] = 5'h12;
    v[15:8] = hi;
    v[7:1] = crc7(v[127:8]);
    v[0] = 1'b1;
    return v;
  endfunction

  function automatic logic [SSR_W-1:0] exp_ssr(input logic [1:0] w);
    logic [SSR_W-1:0] v;
    v = '0;
    v[511:510] = w;
    v[479:440] = {PROT, 8'h04};
    v[431:428] = 4'h9;
    v[423:392] = {16'h0008, 6'h04, 2'h1, 4'h1, 4'h9};
    return v;
  endfunction

  task automatic check_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_vec(input logic [SSR_W-1:0] got, input logic [SSR_W-1:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic run_rest();
    check_vec(ocr_o, 32'hC1FF8000);
    host.read_capacity(rdy, capacity_status_flag);
    check_bit(capacity_status_flag, 1'b1);
    host.relative_card_address(16'hA5C3);
    #1 check_vec(rca_o, 16'hA5C3);
    host.relative_card_address(16'h0001);
    #1 check_vec(rca_o, 16'h0001);
    foreach (rows[i]) begin
      host.prog(rows[i].d, 1'b0);
      #1 check_bit(prog_ack_o, rows[i].ack);
      check_bit(prog_refused_o, rows[i].rf);
      check_vec(csd_o, exp_csd(rows[i].hi));
    end
    // Back to back: an allowed change followed at once by a refused one
    host.prog(16'hA610, 1'b1);
    host.prog(16'h2400, 1'b0);
    #1 check_bit(prog_refused_o, 1'b1);
    check_vec(csd_o, exp_csd(8'hA6));
    foreach (wrows[i]) begin
      host.width(wrows[i].w);
      #1 check_vec(ssr_o, exp_ssr(wrows[i].e));
    end
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    @(posedge sys_clk_i);
    rst_i <= 1'b0;
    #1 check_vec(csd_o, exp_csd(8'h00));
    check_vec(rca_o, 16'h0000);
    check_vec(ssr_o, exp_ssr(2'h0));
    check_vec(ocr_o, 32'h01FF8000);
    check_bit(powered_o, 1'b0);
  endtask

  initial begin
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    #1 check_vec(csd_o, exp_csd(8'h00));
    check_vec(scr_o, 64'h0205848300000000);
    check_vec(erased_fill_o, 8'hFF);
    check_vec(ssr_o, exp_ssr(2'h0));
    check_vec(ocr_o, 32'h01FF8000);
    check_bit(prog_ack_o, 1'b0);
    check_bit(prog_refused_o, 1'b0);
    host.relative_card_address(16'h1234);
    #1 check_vec(rca_o, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk_i);
      #1 check_bit(ocr_o[31], 1'b0);
      check_bit(powered_o, 1'b0);
    end
    for (int k = 0; k < 20 && powered_o !== 1'b1; k++) begin
      @(posedge sys_clk_i);
      #1;
    end
    if (powered_o === 1'b1) begin
      run_rest();
    end else begin
      failures++;
    end
    finish_test();
  end
endmodule
`default_nettype wire
